//--- core/serial_port_mode_control.sv
// serial port control register, mode decode and the shift/async engines
// assumes a synchronous special-register port and a 16x baud tick from an external timer
//
// Operation
// - mode bits decode top bit first: 00, 01, 10, 11 select modes 0 to 3.
// - modes 2/3 with multiprocessor bit: no receive flag when ninth bit is zero.
// - mode 1 with multiprocessor bit: receive flag only on a valid stop bit.
// - mode 0 shift rate: core clock over twelve, or over four when bit set.
// - incoming data accepted only while receive enable is one; a frame already started still completes if it clears.
// - modes 2/3 transmit the tx ninth-bit field as ninth data bit.
// - rx ninth-bit field takes ninth bit in modes 2/3, stop bit in mode 1.
// - tx flag: mode 0 at end of eighth bit, else when stop bit driven.
// - rx flag: mode 0 eighth bit, mode 1 stop sample, modes 2/3 ninth sample.
// - completion flags stay set until software clears them.
// - mode 0 samples receive line two core clocks before shift clock rises.
// - mode 1 frame: start bit, eight data bits, stop bit.
// - mode 1 data goes least significant bit first.
// - mode 1 timing follows the baud timer running at core clock over twelve.
// - mode 0 starts shifting eight bits out, lsb first, on buffer write.
// - mode 0 rx flag one clock after eighth bit, then reception halts.
`timescale 1ns/1ps
`default_nettype none
module serial_port_mode_control (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic baud_tick,
  input wire logic serial_rx_pin_in,
  output logic serial_rx_pin_out,
  output logic serial_rx_pin_oe,
  output logic serial_tx_pin
);

  serial_port_pkg::ctrl_type ctrl, next_ctrl;
  serial_port_pkg::mode_type mode;
  serial_port_pkg::tx_state_type tx_state, next_tx_state;
  serial_port_pkg::rx_state_type rx_state, next_rx_state;
  logic [7:0] next_rdata;
  logic [7:0] rx_buffer, next_rx_buffer;
  logic [10:0] tx_shift, next_tx_shift;
  logic [3:0] tx_count, next_tx_count;
  logic [3:0] tick_count, next_tick_count;
  logic [8:0] rx_shift, next_rx_shift;
  logic [3:0] rx_count, next_rx_count;
  logic [3:0] rx_phase, next_rx_phase;
  logic m0_sample, next_m0_sample;
  logic m0_rx_pending, next_m0_rx_pending;
  logic next_tx_pin, next_rx_out, next_rx_oe;
  logic ctrl_wr, data_wr, tx_roll, rx_last, rx_mid, m0_run;
  logic sample_pulse, rise_pulse, bit_end_pulse;
  logic [8:0] rx_word;

  shift_clock_gen u_shift_clock (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .run(m0_run),
    .fast(ctrl.multiproc_or_speed_select),
    .sample_pulse(sample_pulse),
    .rise_pulse(rise_pulse),
    .bit_end_pulse(bit_end_pulse)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    mode = serial_port_pkg::mode_type'({ctrl.mode_select_high, ctrl.mode_select_low});
    ctrl_wr = sfr_wr && (sfr_addr == serial_port_pkg::CTRL_ADDR);
    data_wr = sfr_wr && (sfr_addr == serial_port_pkg::DATA_ADDR);
    m0_run = (tx_state == serial_port_pkg::TX_SHIFT0) || (rx_state == serial_port_pkg::RX_SHIFT0);
    // the 16x tick comes from the baud timer at core clock over twelve by default
    tx_roll = baud_tick && (tick_count == serial_port_pkg::OVERSAMPLE_LAST);
    rx_mid = baud_tick && (rx_phase == serial_port_pkg::SAMPLE_POINT);
    rx_last = (rx_state == serial_port_pkg::RX_ASYNC) && rx_mid && (rx_count == serial_port_pkg::ASYNC_LAST_SAMPLE);
    rx_word = {serial_rx_pin_in, rx_shift[8:1]};

    next_ctrl = ctrl;
    next_rx_buffer = rx_buffer;
    next_tx_state = tx_state;
    next_tx_shift = tx_shift;
    next_tx_count = tx_count;
    next_tx_pin = serial_tx_pin;
    next_rx_out = serial_rx_pin_out;
    next_rx_oe = serial_rx_pin_oe;
    next_tick_count = baud_tick ? tick_count + 4'h1 : tick_count;
    next_rx_state = rx_state;
    next_rx_shift = rx_shift;
    next_rx_count = rx_count;
    next_rx_phase = baud_tick ? rx_phase + 4'h1 : rx_phase;
    next_m0_sample = sample_pulse ? serial_rx_pin_in : m0_sample;
    next_m0_rx_pending = 1'b0;
    next_rdata = 8'h00;

    if (sfr_rd && sfr_addr == serial_port_pkg::CTRL_ADDR) begin
      next_rdata = ctrl;
    end else if (sfr_rd && sfr_addr == serial_port_pkg::DATA_ADDR) begin
      next_rdata = rx_buffer;
    end

    // software write first; hardware sets below win over a clear in the same cycle
    if (ctrl_wr) begin
      next_ctrl = sfr_wdata;
    end

    case (tx_state)
      serial_port_pkg::TX_IDLE: begin
        if (data_wr && mode == serial_port_pkg::MODE0 && rx_state == serial_port_pkg::RX_IDLE) begin
          next_tx_state = serial_port_pkg::TX_SHIFT0;
          next_tx_shift = {3'b111, sfr_wdata};
          next_tx_count = 4'h0;
          next_rx_out = sfr_wdata[0];
          next_rx_oe = 1'b1;
          next_tx_pin = 1'b0;
        end else if (data_wr && mode != serial_port_pkg::MODE0) begin
          next_tx_state = serial_port_pkg::TX_ASYNC;
          // start bit, data lsb first, then ninth bit or second stop, then stop
          next_tx_shift = {1'b1, (mode == serial_port_pkg::MODE1) ? 1'b1 : ctrl.tx_ninth_bit,
                           sfr_wdata, 1'b0};
          next_tx_count = 4'h0;
        end
      end
      serial_port_pkg::TX_SHIFT0: begin
        if (rise_pulse) begin
          next_tx_pin = 1'b1;
        end
        if (bit_end_pulse) begin
          next_tx_shift = {1'b1, tx_shift[10:1]};
          next_tx_count = tx_count + 4'h1;
          next_rx_out = tx_shift[1];
          next_tx_pin = 1'b0;
          if (tx_count == serial_port_pkg::M0_LAST_BIT) begin
            next_tx_state = serial_port_pkg::TX_IDLE;
            next_tx_pin = 1'b1;
            next_rx_oe = 1'b0;
            next_ctrl.tx_done_flag = 1'b1;
          end
        end
      end
      default: begin
        if (tx_roll) begin
          next_tx_pin = tx_shift[0];
          next_tx_shift = {1'b1, tx_shift[10:1]};
          next_tx_count = tx_count + 4'h1;
          if (tx_count == ((mode == serial_port_pkg::MODE1) ? serial_port_pkg::M1_FRAME_BITS
                                                            : serial_port_pkg::M23_FRAME_BITS) - 4'h1) begin
            next_ctrl.tx_done_flag = 1'b1;
          end
          if (tx_count == ((mode == serial_port_pkg::MODE1) ? serial_port_pkg::M1_FRAME_BITS
                                                            : serial_port_pkg::M23_FRAME_BITS)) begin
            next_tx_state = serial_port_pkg::TX_IDLE;
            next_tx_pin = 1'b1;
          end
        end
      end
    endcase

    case (rx_state)
      serial_port_pkg::RX_IDLE: begin
        // mode 0 waits for the flag to be cleared before shifting again
        if (ctrl.rx_enable && !ctrl.rx_done_flag && mode == serial_port_pkg::MODE0 &&
            tx_state == serial_port_pkg::TX_IDLE && !m0_rx_pending && !data_wr) begin
          next_rx_state = serial_port_pkg::RX_SHIFT0;
          next_rx_count = 4'h0;
          next_tx_pin = 1'b0;
        end else if (ctrl.rx_enable && mode != serial_port_pkg::MODE0 && baud_tick && !serial_rx_pin_in) begin
          next_rx_state = serial_port_pkg::RX_ASYNC;
          next_rx_count = 4'h0;
          next_rx_phase = 4'h0;
        end
      end
      serial_port_pkg::RX_SHIFT0: begin
        if (rise_pulse) begin
          next_tx_pin = 1'b1;
          next_rx_shift = {m0_sample, rx_shift[8:1]};
          next_rx_count = rx_count + 4'h1;
          if (rx_count == serial_port_pkg::M0_LAST_BIT) begin
            next_rx_state = serial_port_pkg::RX_IDLE;
            next_rx_buffer = {m0_sample, rx_shift[8:2]};
            next_m0_rx_pending = 1'b1;
          end
        end
        if (bit_end_pulse) begin
          next_tx_pin = 1'b0;
        end
      end
      default: begin
        if (rx_mid) begin
          next_rx_count = rx_count + 4'h1;
          if (rx_count == 4'h0 && serial_rx_pin_in) begin
            next_rx_state = serial_port_pkg::RX_IDLE;
          end else if (rx_count != 4'h0) begin
            next_rx_shift = rx_word;
          end
        end
        if (rx_last) begin
          next_rx_state = serial_port_pkg::RX_IDLE;
          next_rx_buffer = rx_word[7:0];
          next_ctrl.rx_ninth_bit = serial_rx_pin_in;
          if (!ctrl.multiproc_or_speed_select || serial_rx_pin_in) begin
            next_ctrl.rx_done_flag = 1'b1;
          end
        end
      end
    endcase

    if (m0_rx_pending) begin
      next_ctrl.rx_done_flag = 1'b1;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= serial_port_pkg::CTRL_RESET;
      rx_buffer <= 8'h00;
      sfr_rdata <= 8'h00;
      tx_state <= serial_port_pkg::TX_IDLE;
      rx_state <= serial_port_pkg::RX_IDLE;
      tx_shift <= 11'h7ff;
      tx_count <= 4'h0;
      tick_count <= 4'h0;
      rx_shift <= 9'h000;
      rx_count <= 4'h0;
      rx_phase <= 4'h0;
      m0_sample <= 1'b0;
      m0_rx_pending <= 1'b0;
      serial_tx_pin <= 1'b1;
      serial_rx_pin_out <= 1'b1;
      serial_rx_pin_oe <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      rx_buffer <= next_rx_buffer;
      sfr_rdata <= next_rdata;
      tx_state <= next_tx_state;
      rx_state <= next_rx_state;
      tx_shift <= next_tx_shift;
      tx_count <= next_tx_count;
      tick_count <= next_tick_count;
      rx_shift <= next_rx_shift;
      rx_count <= next_rx_count;
      rx_phase <= next_rx_phase;
      m0_sample <= next_m0_sample;
      m0_rx_pending <= next_m0_rx_pending;
      serial_tx_pin <= next_tx_pin;
      serial_rx_pin_out <= next_rx_out;
      serial_rx_pin_oe <= next_rx_oe;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_MODE1_START: assert property ((tx_state == serial_port_pkg::TX_IDLE && data_wr &&
      !ctrl.mode_select_high && ctrl.mode_select_low) |=> tx_state == serial_port_pkg::TX_ASYNC)
    else $error("mode 1 write did not start async transmit");
  AST_MP_NINTH_ZERO: assert property ((rx_last && mode[1] && ctrl.multiproc_or_speed_select &&
      !serial_rx_pin_in && !ctrl.rx_done_flag && !ctrl_wr && !m0_rx_pending) |=> !ctrl.rx_done_flag)
    else $error("receive flag set with ninth bit zero");
  AST_BAD_STOP: assert property ((rx_last && mode == serial_port_pkg::MODE1 && ctrl.multiproc_or_speed_select &&
      !serial_rx_pin_in && !ctrl.rx_done_flag && !ctrl_wr) |=> !ctrl.rx_done_flag)
    else $error("receive flag set without valid stop");
  AST_RX_DISABLED: assert property ((!ctrl.rx_enable && rx_state == serial_port_pkg::RX_IDLE)
      |=> rx_state == serial_port_pkg::RX_IDLE)
    else $error("reception started while disabled");
  AST_NINTH_OUT: assert property ((tx_state == serial_port_pkg::TX_IDLE && data_wr && mode[1])
      |=> tx_shift[9] == $past(ctrl.tx_ninth_bit))
    else $error("ninth transmit bit wrong");
  AST_RB8_CAPTURE: assert property (rx_last |=> ctrl.rx_ninth_bit == $past(serial_rx_pin_in))
    else $error("received ninth or stop bit not captured");
  AST_M0_TX_DONE: assert property ((tx_state == serial_port_pkg::TX_SHIFT0 && bit_end_pulse && tx_count == 4'h7)
      |=> ctrl.tx_done_flag && !serial_rx_pin_oe && tx_state == serial_port_pkg::TX_IDLE)
    else $error("mode 0 transmit completion wrong");
  AST_FLAG_STICKY: assert property ((ctrl.tx_done_flag && !ctrl_wr) |=> ctrl.tx_done_flag)
    else $error("transmit flag cleared without software");
  AST_M0_RX_DONE: assert property ((rx_state == serial_port_pkg::RX_SHIFT0 && rise_pulse && rx_count == 4'h7)
      |-> ##2 ctrl.rx_done_flag ##1 (rx_state == serial_port_pkg::RX_IDLE))
    else $error("mode 0 receive flag timing wrong");

  COV_M0_TX: cover property (tx_state == serial_port_pkg::TX_SHIFT0 ##[1:200] ctrl.tx_done_flag);
  COV_M0_RX: cover property (rx_state == serial_port_pkg::RX_SHIFT0 ##[1:200] ctrl.rx_done_flag);
  COV_ASYNC_RX: cover property (rx_last && mode == serial_port_pkg::MODE1);
  COV_MP_DROP: cover property (rx_last && mode[1] && ctrl.multiproc_or_speed_select && !serial_rx_pin_in);

endmodule // serial_port_mode_control
`default_nettype wire

//--- core/serial_port_pkg.sv
// constants, field layout and types for the serial port control block
// assumes one core clock and an 8-bit special-register port for software access
package serial_port_pkg;

  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'hc0;
  localparam logic [7:0] DATA_ADDR = 8'hc1;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ----------------------------------------
  // timing and framing counts
  // ----------------------------------------
  localparam logic [3:0] M0_SLOW_DIV = 4'hc;
  localparam logic [3:0] M0_FAST_DIV = 4'h4;
  localparam logic [3:0] M0_SAMPLE_LEAD = 4'h2;
  localparam logic [3:0] M0_LAST_BIT = 4'h7;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_POINT = 4'h7;
  localparam logic [3:0] ASYNC_LAST_SAMPLE = 4'h9;
  localparam logic [3:0] M1_FRAME_BITS = 4'ha;
  localparam logic [3:0] M23_FRAME_BITS = 4'hb;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {MODE0, MODE1, MODE2, MODE3} mode_type;

  typedef struct packed {
    logic mode_select_high;
    logic mode_select_low;
    logic multiproc_or_speed_select;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } ctrl_type;

  typedef enum {TX_IDLE, TX_SHIFT0, TX_ASYNC} tx_state_type;
  typedef enum {RX_IDLE, RX_SHIFT0, RX_ASYNC} rx_state_type;

endpackage

//--- core/shift_clock_gen.sv
// mode 0 shift clock timing: bit period of 12 or 4 core clocks
// assumes run is held for whole bits by the serial port control block, except mode 0 receive, which drops it at the eighth rise
`timescale 1ns/1ps
`default_nettype none
module shift_clock_gen (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic run,
  input wire logic fast,
  output logic sample_pulse,
  output logic rise_pulse,
  output logic bit_end_pulse
);

  logic [3:0] count;
  logic [3:0] next_count;
  logic [3:0] period;
  logic [3:0] half;
  logic [3:0] gap;
  logic [3:0] next_gap;

  // ----------------------------------------
  // bit period counter
  // ----------------------------------------
  always_comb begin
    period = fast ? serial_port_pkg::M0_FAST_DIV : serial_port_pkg::M0_SLOW_DIV;
    half = period >> 1;
    // sampling leads the rising edge on the pin by two core clocks
    sample_pulse = run && (count == half - serial_port_pkg::M0_SAMPLE_LEAD);
    rise_pulse = run && (count == half);
    bit_end_pulse = run && (count == period - 4'h1);
    next_count = 4'h0;
    if (run && !bit_end_pulse) begin
      next_count = count + 4'h1;
    end
    // cycles since the last rise, saturating; feeds the rate checks
    next_gap = 4'h0;
    if (run && rise_pulse) begin
      next_gap = 4'h1;
    end else if (run && gap != 4'h0) begin
      next_gap = (gap == 4'hf) ? gap : gap + 4'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      count <= 4'h0;
      gap <= 4'h0;
    end else begin
      count <= next_count;
      gap <= next_gap;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_SLOW_RATE: assert property ((rise_pulse && !fast && gap != 4'h0)
      |-> gap == serial_port_pkg::M0_SLOW_DIV)
    else $error("slow shift clock period is not twelve cycles");
  AST_FAST_RATE: assert property ((rise_pulse && fast && gap != 4'h0)
      |-> gap == serial_port_pkg::M0_FAST_DIV)
    else $error("fast shift clock period is not four cycles");
  AST_SAMPLE_LEAD: assert property ((sample_pulse ##1 run) |=> rise_pulse)
    else $error("sample does not lead the rising edge by two cycles");

endmodule // shift_clock_gen
`default_nettype wire

//--- tb/serial_peer.sv
// remote serial peer: async frames and a mode 0 shift register
// assumes baud_tick is the 16x tick and the rx line idles high on a pull-up
`timescale 1ns/1ps
`default_nettype none
module serial_peer (
  input wire logic clk_sys,
  input wire logic baud_tick,
  input wire logic tx_pin,
  input wire logic line_in,
  output logic line_drive
);
  initial line_drive = 1'b1;

  task automatic wait_ticks(input int n);
    repeat (n) begin
      @(posedge clk_sys);
      while (baud_tick !== 1'b1) @(posedge clk_sys);
    end
  endtask

  // start, data lsb first, optional ninth, stop
  task automatic send_async(input int n, input logic [10:0] bits);
    wait_ticks(1);
    for (int i = 0; i < n; i++) begin
      #1 line_drive = bits[i];
      wait_ticks(16);
    end
    #1 line_drive = 1'b1;
  endtask

  // mid-bit sampling of the device's tx pin
  task automatic recv_async(input int n, output logic [10:0] bits);
    bits = '1;
    @(negedge tx_pin);
    wait_ticks(8);
    for (int i = 0; i < n; i++) begin
      bits[i] = tx_pin;
      wait_ticks(16);
    end
  endtask

  // shift register clocked by the device: takes a bit on each rise
  task automatic m0_capture(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(posedge tx_pin);
      d[i] = line_in;
    end
  endtask

  // next bit right after each rise, steady over the sample point
  task automatic m0_supply(input logic [7:0] d);
    line_drive = d[0];
    for (int i = 1; i < 9; i++) begin
      @(posedge tx_pin);
      #1 line_drive = (i < 8) ? d[i] : 1'b1;
    end
  endtask
endmodule // serial_peer
`default_nettype wire

//--- tb/serial_port_mode_control_test.sv
// self-checking bench for the serial port control block
// assumes the peer model on the rx line and a 16x tick every second core clock
`timescale 1ns/1ps
`default_nettype none
module serial_port_mode_control_test;
  localparam logic [7:0] CTRL = serial_port_pkg::CTRL_ADDR;
  localparam logic [7:0] DATA = serial_port_pkg::DATA_ADDR;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic baud_tick = 1'b0;
  wire logic [7:0] sfr_rdata;
  wire logic rx_out;
  wire logic rx_oe;
  wire logic tx_pin;
  wire logic peer_drive;
  wire logic rx_line;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;

  // the rx pin is shared: device drives it only in mode 0 transmit
  assign rx_line = rx_oe ? rx_out : peer_drive;
  always #2.5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    baud_tick <= #1 ~baud_tick;
    if (cycles == 60000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  serial_port_mode_control dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .baud_tick(baud_tick),
    .serial_rx_pin_in(rx_line), .serial_rx_pin_out(rx_out), .serial_rx_pin_oe(rx_oe), .serial_tx_pin(tx_pin));
  serial_peer peer_u (.clk_sys(clk_sys), .baud_tick(baud_tick), .tx_pin(tx_pin), .line_in(rx_line),
    .line_drive(peer_drive));

  // --------------------------------
  // tasks and expectations
  // --------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [10:0] got, input logic [10:0] exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask

  // all bus tasks start and end 1 ns after a rising edge
  // one idle edge after each access: a strobe never drops and rises in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    step(1);
    sfr_wr = 1'b0;
    step(1);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    step(1);
    sfr_rd = 1'b0;
    d = sfr_rdata;
    step(1);
  endtask

  // back-to-back control reads until a flag shows; n counts the edges
  task automatic poll(input logic [7:0] mask, output int n);
    logic [7:0] d;
    n = 0;
    d = 8'h00;
    sfr_addr = CTRL;
    sfr_rd = 1'b1;
    while ((d & mask) === 8'h00 && n < 200) begin
      step(1);
      d = sfr_rdata;
      n++;
    end
    sfr_rd = 1'b0;
    step(1);
  endtask

  function automatic logic [10:0] frame(input logic [1:0] m, input logic [7:0] d, input logic b9);
    return (m == 2'b01) ? {2'b11, d, 1'b0} : {1'b1, b9, d, 1'b0};
  endfunction

  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    logic [7:0] d;
    logic [7:0] got;
    logic [7:0] r;
    logic [10:0] fr;
    logic [10:0] bits;
    logic b9;
    int n;
    int div;
    void'($urandom(32'hcc68));
    step(8);
    rst_n = 1'b1;
    step(1);
    rd(CTRL, r);
    chk(r, serial_port_pkg::CTRL_RESET, "control after reset");
    rd(8'h55, r);
    chk(r, 8'h00, "unmapped read");
    d = 8'($urandom()) & 8'hef;
    wr(CTRL, d);
    rd(CTRL, r);
    chk(r, d, "control readback");
    for (int sp = 0; sp < 2; sp++) begin
      div = sp ? serial_port_pkg::M0_FAST_DIV : serial_port_pkg::M0_SLOW_DIV;
      wr(CTRL, sp ? 8'h20 : 8'h00);
      d = $urandom();
      fork
        peer_u.m0_capture(got);
        begin
          wr(DATA, d);
          poll(8'h02, n);
        end
      join
      chk(got, d, "mode 0 shifted byte");
      // flag one edge after the eighth bit ends; poll starts after the idle edge
      chk(n, 8 * div, "mode 0 tx flag time");
      step(20);
      rd(CTRL, r);
      chk(r[1], 1'b1, "tx flag held");
      d = $urandom();
      fork
        peer_u.m0_supply(d);
      join_none
      wr(CTRL, sp ? 8'h30 : 8'h10);
      poll(8'h01, n);
      chk(n < 200, 1'b1, "mode 0 rx flag");
      rd(DATA, r);
      chk(r, d, "mode 0 received byte");
      n = 0;
      for (int i = 0; i < 60; i++) begin
        step(1);
        if (tx_pin !== 1'b1) n++;
      end
      chk(n, 0, "shift clock stopped while flag set");
      wr(CTRL, 8'h00);
    end
    for (int m = 1; m < 4; m++) begin
      b9 = 1'($urandom());
      d = $urandom();
      wr(CTRL, {m[1:0], 2'b00, b9, 3'b000});
      fork
        peer_u.recv_async(m == 1 ? 10 : 11, bits);
        wr(DATA, d);
      join
      chk(bits, frame(m[1:0], d, b9), "async frame on tx pin");
      rd(CTRL, r);
      chk(r[1], 1'b1, "async tx flag");
      // c: 0 plain, 1 multiproc with zero last bit, 2 receive disabled
      for (int c = 0; c < 3; c++) begin
        d = $urandom();
        b9 = (m == 1) ? (c != 1) : ((c != 1) & 1'($urandom()));
        fr = frame(m[1:0], d, b9);
        if (m == 1) fr[9] = b9;
        wr(CTRL, {m[1:0], c == 1, c != 2, 4'h0});
        peer_u.send_async(m == 1 ? 10 : 11, fr);
        step(80);
        rd(CTRL, r);
        chk(r[0], c == 0, "async rx flag");
        if (c == 0) begin
          chk(r[2], b9, "rx ninth field");
          rd(DATA, r);
          chk(r, d, "async received byte");
        end
      end
    end
    report_and_stop();
  end
endmodule // serial_port_mode_control_test
`default_nettype wire
